// file: core/cgs_cfg_if.sv
// Interface carrying configuration from the register file to the pin stage
`default_nettype none
interface cgs_cfg_if;
    logic [7:0] func;
    logic [7:0] dir;
    logic [7:0] drive;
    logic [7:0] olevel;
    logic force_analog;
    modport regs (output func, output dir, output drive, output olevel, output force_analog);
    modport pins (input func, input dir, input drive, input olevel, input force_analog);
endinterface : cgs_cfg_if
`default_nettype wire

// file: core/cgs_pin_stage.sv
// Pin stage: drive decode and two-flop input synchroniser for the eight channels
`default_nettype none
module cgs_pin_stage (
    input wire logic aclk,
    input wire logic aresetn,
    cgs_cfg_if.pins cfg,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    output logic [7:0] analog_sel,
    output logic [7:0] input_level_bits
);
    logic [7:0] sync1_ff;
    logic [7:0] sync2_ff;
    logic [7:0] is_gpio;
    logic [7:0] is_out;
    logic [7:0] nxt_o;
    logic [7:0] nxt_oe;
    logic [7:0] o_ff;
    logic [7:0] oe_ff;

    assign is_gpio = cfg.force_analog ? cgs_pkg::RST_ZERO : cfg.func;
    assign is_out = is_gpio & cfg.dir;
    assign analog_sel = ~is_gpio;
    // Open drain only pulls low; push-pull drives both levels
    assign nxt_o = cfg.olevel & cfg.drive;
    assign nxt_oe = is_out & (cfg.drive | ~cfg.olevel);
    assign pin_o = o_ff;
    assign pin_oe = oe_ff;
    assign input_level_bits = sync2_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= cgs_pkg::RST_ZERO;
            sync2_ff <= cgs_pkg::RST_ZERO;
            o_ff <= cgs_pkg::RST_ZERO;
            oe_ff <= cgs_pkg::RST_ZERO;
        end else begin
            sync1_ff <= pin_i;
            sync2_ff <= sync1_ff;
            o_ff <= nxt_o;
            oe_ff <= nxt_oe;
        end
    end
endmodule : cgs_pin_stage
`default_nettype wire

// file: core/cgs_pkg.sv
// Package of register map, field layout and modes for the channel pin sequencer bank
`default_nettype none
package cgs_pkg;
    // Register indices; not all multiples of four, so byte address = 4 * index
    localparam logic [7:0] IDX_TIMING = 8'h04;
    localparam logic [7:0] IDX_FUNC = 8'h05;
    localparam logic [7:0] IDX_DIR = 8'h07;
    localparam logic [7:0] IDX_DRIVE = 8'h09;
    localparam logic [7:0] IDX_OLEVEL = 8'h0B;
    localparam logic [7:0] IDX_ILEVEL = 8'h0D;
    localparam logic [7:0] IDX_SCAN = 8'h10;
    localparam logic [7:0] IDX_MANUAL = 8'h11;
    localparam logic [7:0] IDX_MASK = 8'h12;
    localparam logic [7:0] IDX_GENCTL = 8'h01;
    localparam logic [7:0] IDX_STATUS = 8'h00;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_W = 10;
    // Reset values
    localparam logic [7:0] RST_TIMING = 8'h04;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // Writable masks (reserved bits read zero, writes ignored)
    localparam logic [7:0] WM_TIMING = 8'h1F;
    localparam logic [7:0] WM_SCAN = 8'h13;
    localparam logic [7:0] WM_MANUAL = 8'h0F;
    localparam logic [7:0] WM_GENCTL = 8'h04;
    localparam logic [7:0] WM_ALL = 8'hFF;
    // Field positions
    localparam int OSC_BIT = 4;
    localparam int RUN_BIT = 4;
    localparam int FAA_BIT = 2;
    localparam int ACTIVE_BIT = 6;
    localparam int NCH = 8;
    // Wait count that ends each scan step; channel steps come 18 clock cycles apart
    localparam logic [7:0] STEP_CYCLES = 8'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        CGS_MODE_MANUAL = 2'b00,
        CGS_MODE_AUTO = 2'b01,
        CGS_MODE_FLY = 2'b10,
        CGS_MODE_RSVD = 2'b11
    } cgs_mode_e;
    typedef enum logic [1:0] {
        CGS_SEQ_IDLE = 2'b00,
        CGS_SEQ_WAIT = 2'b01,
        CGS_SEQ_STEP = 2'b10
    } cgs_seq_e;
endpackage : cgs_pkg
`default_nettype wire

// file: core/cgs_regs.sv
// Register bank with AXI4-Lite slave, pin control and channel scan sequencer
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
module cgs_regs (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    output logic [7:0] analog_sel,
    output logic low_power_osc,
    output logic [3:0] rate_divider,
    output logic [1:0] scan_mode,
    output logic [3:0] convert_channel,
    output logic convert_channel_valid,
    output logic scan_active
);
    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0] timing_source_ctrl_ff;
    logic [7:0] channel_function_map_ff;
    logic [7:0] pin_direction_map_ff;
    logic [7:0] output_drive_type_map_ff;
    logic [7:0] output_level_map_ff;
    logic [7:0] scan_control_ff;
    logic [7:0] manual_channel_pick_ff;
    logic [7:0] scan_channel_mask_ff;
    logic [7:0] general_ctrl_ff;
    logic [7:0] input_level_bits;
    cgs_cfg_if cfg ();

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    logic aw_held_ff;
    logic w_held_ff;
    logic [9:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic [9:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_lane0;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] wr_idx;

    localparam int ADDR_HI = cgs_pkg::ADDR_W - 1;
    function automatic logic [7:0] addr_idx(input logic [9:0] a);
        addr_idx = a[ADDR_HI:cgs_pkg::ADDR_LSB];
    endfunction : addr_idx

    function automatic logic idx_mapped(input logic [7:0] i);
        idx_mapped = (i == cgs_pkg::IDX_TIMING) || (i == cgs_pkg::IDX_FUNC)
            || (i == cgs_pkg::IDX_DIR) || (i == cgs_pkg::IDX_DRIVE)
            || (i == cgs_pkg::IDX_OLEVEL) || (i == cgs_pkg::IDX_ILEVEL)
            || (i == cgs_pkg::IDX_SCAN) || (i == cgs_pkg::IDX_MANUAL)
            || (i == cgs_pkg::IDX_MASK) || (i == cgs_pkg::IDX_GENCTL)
            || (i == cgs_pkg::IDX_STATUS);
    endfunction : idx_mapped

    // Merge masked write data into a register
    function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] d,
                                          input logic [7:0] m);
        wmerge = (old & ~m) | (d & m);
    endfunction : wmerge

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready = !w_held_ff && !bvalid_ff;
    assign wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
    assign wr_lane0 = w_held_ff ? wstrb_ff[0] : s_axi_wstrb[0];
    assign wr_fire = (aw_held_ff || (s_axi_awvalid && s_axi_awready))
        && (w_held_ff || (s_axi_wvalid && s_axi_wready));
    assign wr_idx = addr_idx(wr_addr);
    assign wr_hit = idx_mapped(wr_idx);
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    function automatic logic wr_to(input logic [7:0] i);
        wr_to = wr_fire && wr_lane0 && (wr_idx == i);
    endfunction : wr_to

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
            bvalid_ff <= 1'b0;
            bresp_ff <= cgs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Register updates
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timing_source_ctrl_ff <= cgs_pkg::RST_TIMING;
            channel_function_map_ff <= cgs_pkg::RST_ZERO;
            pin_direction_map_ff <= cgs_pkg::RST_ZERO;
            output_drive_type_map_ff <= cgs_pkg::RST_ZERO;
            output_level_map_ff <= cgs_pkg::RST_ZERO;
            scan_control_ff <= cgs_pkg::RST_ZERO;
            manual_channel_pick_ff <= cgs_pkg::RST_ZERO;
            scan_channel_mask_ff <= cgs_pkg::RST_ZERO;
            general_ctrl_ff <= cgs_pkg::RST_ZERO;
        end else begin
            // Reserved positions are masked off on write
            if (wr_to(cgs_pkg::IDX_TIMING))
                timing_source_ctrl_ff <= wmerge(timing_source_ctrl_ff, wr_data[7:0],
                                                cgs_pkg::WM_TIMING);
            if (wr_to(cgs_pkg::IDX_FUNC))
                channel_function_map_ff <= wr_data[7:0];
            if (wr_to(cgs_pkg::IDX_DIR))
                pin_direction_map_ff <= wr_data[7:0];
            if (wr_to(cgs_pkg::IDX_DRIVE))
                output_drive_type_map_ff <= wr_data[7:0];
            if (wr_to(cgs_pkg::IDX_OLEVEL))
                output_level_map_ff <= wr_data[7:0];
            if (wr_to(cgs_pkg::IDX_SCAN))
                scan_control_ff <= wmerge(scan_control_ff, wr_data[7:0],
                                          cgs_pkg::WM_SCAN);
            if (wr_to(cgs_pkg::IDX_MANUAL))
                manual_channel_pick_ff <= wmerge(manual_channel_pick_ff, wr_data[7:0],
                                                 cgs_pkg::WM_MANUAL);
            if (wr_to(cgs_pkg::IDX_MASK))
                scan_channel_mask_ff <= wr_data[7:0];
            if (wr_to(cgs_pkg::IDX_GENCTL))
                general_ctrl_ff <= wmerge(general_ctrl_ff, wr_data[7:0],
                                          cgs_pkg::WM_GENCTL);
        end
    end

    // ****************************************************************
    // Pin stage
    // ****************************************************************
    assign cfg.func = channel_function_map_ff;
    assign cfg.dir = pin_direction_map_ff;
    assign cfg.drive = output_drive_type_map_ff;
    assign cfg.olevel = output_level_map_ff;
    assign cfg.force_analog = general_ctrl_ff[cgs_pkg::FAA_BIT];

    cgs_pin_stage u_pins (
        .aclk(aclk),
        .aresetn(aresetn),
        .cfg(cfg),
        .pin_i(pin_i),
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .analog_sel(analog_sel),
        .input_level_bits(input_level_bits)
    );

    assign low_power_osc = timing_source_ctrl_ff[cgs_pkg::OSC_BIT];
    assign rate_divider = timing_source_ctrl_ff[3:0];
    assign scan_mode = scan_control_ff[1:0];

    // ****************************************************************
    // Channel scan sequencer
    // ****************************************************************
    cgs_pkg::cgs_seq_e seq_ff;
    cgs_pkg::cgs_seq_e nxt_seq;
    logic [2:0] cur_ch_ff;
    logic [2:0] nxt_ch;
    logic [7:0] step_cnt_ff;
    logic auto_mode;
    logic run_req;
    logic [7:0] en_mask;
    logic [2:0] next_en;
    logic next_found;
    logic step_done;

    assign auto_mode = (scan_mode == cgs_pkg::CGS_MODE_AUTO);
    assign run_req = auto_mode && scan_control_ff[cgs_pkg::RUN_BIT];
    // Only channels that are analog inputs take part
    assign en_mask = scan_channel_mask_ff & analog_sel;
    assign step_done = (step_cnt_ff == cgs_pkg::STEP_CYCLES);

    // Next enabled channel above current, wrapping to the lowest
    always_comb begin
        next_en = 3'h0;
        next_found = 1'b0;
        for (int k = cgs_pkg::NCH - 1; k >= 0; k--) begin
            if (en_mask[k]) begin
                next_en = 3'(k);
                next_found = 1'b1;
            end
        end
        for (int k = cgs_pkg::NCH - 1; k >= 0; k--) begin
            if (en_mask[k] && (3'(k) > cur_ch_ff)) begin
                next_en = 3'(k);
            end
        end
    end

    always_comb begin
        nxt_seq = seq_ff;
        nxt_ch = cur_ch_ff;
        case (seq_ff)
            cgs_pkg::CGS_SEQ_IDLE: begin
                if (run_req && next_found) begin
                    nxt_seq = cgs_pkg::CGS_SEQ_WAIT;
                    nxt_ch = next_en;
                end
            end
            cgs_pkg::CGS_SEQ_WAIT: begin
                if (!run_req || !next_found) begin
                    nxt_seq = cgs_pkg::CGS_SEQ_IDLE;
                end else if (step_done) begin
                    nxt_seq = cgs_pkg::CGS_SEQ_STEP;
                end
            end
            cgs_pkg::CGS_SEQ_STEP: begin
                nxt_seq = (run_req && next_found) ? cgs_pkg::CGS_SEQ_WAIT : cgs_pkg::CGS_SEQ_IDLE;
                nxt_ch = next_en;
            end
            default: nxt_seq = cgs_pkg::CGS_SEQ_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_ff <= cgs_pkg::CGS_SEQ_IDLE;
            cur_ch_ff <= 3'h7;
            step_cnt_ff <= '0;
        end else begin
            seq_ff <= nxt_seq;
            cur_ch_ff <= (nxt_seq == cgs_pkg::CGS_SEQ_IDLE) ? 3'h7 : nxt_ch;
            step_cnt_ff <= (seq_ff == cgs_pkg::CGS_SEQ_WAIT) ? step_cnt_ff + 8'h01 : 8'h00;
        end
    end

    assign scan_active = (seq_ff != cgs_pkg::CGS_SEQ_IDLE);

    // Manual picks with top bit set are reserved and never flagged valid
    always_comb begin
        convert_channel = 4'h0;
        convert_channel_valid = 1'b0;
        case (scan_mode)
            cgs_pkg::CGS_MODE_MANUAL: begin
                convert_channel = manual_channel_pick_ff[3:0];
                convert_channel_valid = !manual_channel_pick_ff[3];
            end
            cgs_pkg::CGS_MODE_AUTO: begin
                convert_channel = {1'b0, cur_ch_ff};
                convert_channel_valid = scan_active;
            end
            default: begin
                convert_channel = 4'h0;
                convert_channel_valid = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [7:0] rd_idx;
    logic [7:0] rd_val;
    logic [7:0] status_val;

    assign rd_idx = addr_idx(s_axi_araddr);
    assign status_val = {1'b0, scan_active, 6'h00};
    assign rd_val =
        (rd_idx == cgs_pkg::IDX_TIMING) ? (timing_source_ctrl_ff & cgs_pkg::WM_TIMING) :
        (rd_idx == cgs_pkg::IDX_FUNC) ? channel_function_map_ff :
        (rd_idx == cgs_pkg::IDX_DIR) ? pin_direction_map_ff :
        (rd_idx == cgs_pkg::IDX_DRIVE) ? output_drive_type_map_ff :
        (rd_idx == cgs_pkg::IDX_OLEVEL) ? output_level_map_ff :
        (rd_idx == cgs_pkg::IDX_ILEVEL) ? input_level_bits :
        (rd_idx == cgs_pkg::IDX_SCAN) ? (scan_control_ff & cgs_pkg::WM_SCAN) :
        (rd_idx == cgs_pkg::IDX_MANUAL) ? (manual_channel_pick_ff & cgs_pkg::WM_MANUAL) :
        (rd_idx == cgs_pkg::IDX_MASK) ? scan_channel_mask_ff :
        (rd_idx == cgs_pkg::IDX_GENCTL) ? (general_ctrl_ff & cgs_pkg::WM_GENCTL) :
        (rd_idx == cgs_pkg::IDX_STATUS) ? status_val : cgs_pkg::RST_ZERO;

    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= cgs_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h000000, rd_val};
            rresp_ff <= idx_mapped(rd_idx) ? cgs_pkg::RESP_OKAY : cgs_pkg::RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end
endmodule : cgs_regs
`default_nettype wire

// file: test/cgs_pin_pad.sv
// Pin pad model: resolves each channel wire
`default_nettype none
module cgs_pin_pad (
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Wire level
    // ****
    // Released lines float high unless ext_en drives ext_val onto them, as open-drain needs
    assign pad = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en);
endmodule : cgs_pin_pad
`default_nettype wire

// file: test/cgs_regs_sva.sv
// Concurrent checks on the register bank ports
`default_nettype none
module cgs_regs_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] analog_sel,
    input wire logic low_power_osc,
    input wire logic [3:0] rate_divider,
    input wire logic [1:0] scan_mode,
    input wire logic [3:0] convert_channel,
    input wire logic convert_channel_valid,
    input wire logic scan_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Properties
    // ****
    wire logic wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_wstrb[0];
    wire logic [7:0] wi = s_axi_awaddr[9:2];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_osc;
        wr && wi == cgs_pkg::IDX_TIMING |=> low_power_osc == $past(s_axi_wdata[4]);
    endproperty
    a_osc: assert property (p_osc)
        else $error("osc choice not taken");
    property p_div;
        wr && wi == cgs_pkg::IDX_TIMING |=> rate_divider == $past(s_axi_wdata[3:0]);
    endproperty
    a_div: assert property (p_div)
        else $error("divider not taken");
    property p_force;
        wr && wi == cgs_pkg::IDX_GENCTL && s_axi_wdata[2] |=> analog_sel == 8'hFF
            ##1 pin_oe == 8'h00;
    endproperty
    a_force: assert property (p_force)
        else $error("forced analog still drives");
    property p_fly;
        scan_mode[1] |-> !convert_channel_valid;
    endproperty
    a_fly: assert property (p_fly)
        else $error("valid in fly or reserved mode");
    property p_man;
        wr && wi == cgs_pkg::IDX_MANUAL && scan_mode == cgs_pkg::CGS_MODE_MANUAL
            |=> convert_channel == $past(s_axi_wdata[3:0]);
    endproperty
    a_man: assert property (p_man)
        else $error("manual channel not followed");
    property p_stop;
        scan_mode != cgs_pkg::CGS_MODE_AUTO |=> !scan_active;
    endproperty
    a_stop: assert property (p_stop)
        else $error("scan runs outside auto mode");
    property p_rsv;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("upper read bits not zero");
    property p_bv;
        wr |=> s_axi_bvalid;
    endproperty
    a_bv: assert property (p_bv)
        else $error("write not answered");
    property p_rst;
        disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !scan_active
            && pin_oe == 8'h00 && rate_divider == 4'h4 && !low_power_osc;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset state wrong");
endmodule : cgs_regs_sva
bind cgs_regs cgs_regs_sva u_sva (.*);
`default_nettype wire

// file: test/tb_channel_gpio_sequencer_regs.sv
// Self-checking bench for the register bank
`default_nettype none
module tb_channel_gpio_sequencer_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Harness
    // ****
    logic aclk, aresetn, awv, wv, bv, br, arv, rv, rr, awr, wrd, arr, osc, cv, act;
    logic [9:0] awa, ara;
    logic [31:0] wd, rd;
    logic [3:0] ws, div, cch;
    logic [1:0] bresp, rresp, mode;
    logic [7:0] po, poe, asel, pad, ext_en, ext_val;
    int n_fail = 0;
    int samples_checked = 0;
    logic [7:0] zi [10] = '{cgs_pkg::IDX_FUNC, cgs_pkg::IDX_DIR, cgs_pkg::IDX_DRIVE,
        cgs_pkg::IDX_OLEVEL, cgs_pkg::IDX_ILEVEL, cgs_pkg::IDX_SCAN, cgs_pkg::IDX_MANUAL,
        cgs_pkg::IDX_MASK, cgs_pkg::IDX_GENCTL, cgs_pkg::IDX_STATUS};
    cgs_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_i(pad), .pin_o(po),
        .pin_oe(poe), .analog_sel(asel), .low_power_osc(osc), .rate_divider(div),
        .scan_mode(mode), .convert_channel(cch), .convert_channel_valid(cv),
        .scan_active(act));
    cgs_pin_pad u_pad (.pin_o(po), .pin_oe(poe), .ext_en(ext_en), .ext_val(ext_val),
        .pad(pad));
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    // ****
    // AXI4-Lite master
    // ****
    task automatic axw(input logic [7:0] i, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awa <= {i, 2'h0};
        wd <= {24'h000000, d};
        ws <= 4'hF;
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (awv && awr) awv <= 1'h0;
            if (wv && wrd) wv <= 1'h0;
            n++;
        end while (bv !== 1'h1 && n < 50);
        r = bresp;
        br <= 1'h0;
        if (n >= 50) n_fail++;
    endtask : axw
    task automatic axr(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        ara <= {i, 2'h0};
        arv <= 1'h1;
        rr <= 1'h1;
        n = 0;
        do begin
            @(posedge aclk);
            if (arv && arr) arv <= 1'h0;
            n++;
        end while (rv !== 1'h1 && n < 50);
        d = rd;
        r = rresp;
        rr <= 1'h0;
        if (n >= 50) n_fail++;
    endtask : axr
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        logic [1:0] r;
        axw(i, d, r);
        chk("bresp", 32'h0, {30'h0, r});
    endtask : wreg
    task automatic rchk(input string nm, input logic [7:0] i, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axr(i, d, r);
        chk(nm, {24'h000000, e}, d);
        chk("rresp", 32'h0, {30'h0, r});
    endtask : rchk
    function automatic logic [3:0] up(input logic [7:0] m, input logic [3:0] c);
        for (int k = 1; k <= 8; k++) if (m[(c + k) % 8]) return 4'((c + k) % 8);
        return c;
    endfunction : up
    // ****
    // Scenarios
    // ****
    task automatic t_reset;
        rchk("timing", cgs_pkg::IDX_TIMING, 8'h04);
        for (int k = 0; k < 10; k++) rchk("zero reg", zi[k], 8'h00);
        chk("osc", 32'h0, {31'h0, osc});
        chk("div", 32'h4, {28'h0, div});
        $display("test reset done");
    endtask : t_reset
    task automatic t_fields;
        logic [31:0] d;
        logic [1:0] r;
        wreg(cgs_pkg::IDX_TIMING, 8'hFF);
        chk("osc", 32'h1, {31'h0, osc});
        chk("div", 32'hF, {28'h0, div});
        rchk("timing", cgs_pkg::IDX_TIMING, 8'h1F);
        wreg(cgs_pkg::IDX_TIMING, 8'hE0);
        chk("osc", 32'h0, {31'h0, osc});
        rchk("timing", cgs_pkg::IDX_TIMING, 8'h00);
        wreg(cgs_pkg::IDX_SCAN, 8'hFF);
        rchk("scan", cgs_pkg::IDX_SCAN, 8'h13);
        wreg(cgs_pkg::IDX_SCAN, 8'h00);
        wreg(cgs_pkg::IDX_MANUAL, 8'hF3);
        rchk("manual", cgs_pkg::IDX_MANUAL, 8'h03);
        wreg(cgs_pkg::IDX_ILEVEL, 8'hFF);
        rchk("input level", cgs_pkg::IDX_ILEVEL, 8'h00);
        axw(8'h20, 8'h55, r);
        chk("bresp", 32'h2, {30'h0, r});
        axr(8'h20, d, r);
        chk("unmapped", 32'h0, d);
        chk("rresp", 32'h2, {30'h0, r});
        $display("test fields done");
    endtask : t_fields
    task automatic t_pins;
        wreg(cgs_pkg::IDX_FUNC, 8'hFF);
        wreg(cgs_pkg::IDX_DIR, 8'h0F);
        wreg(cgs_pkg::IDX_DRIVE, 8'h03);
        wreg(cgs_pkg::IDX_OLEVEL, 8'h05);
        ext_en <= 8'hF0;
        ext_val <= 8'hA0;
        repeat (4) @(posedge aclk);
        chk("pin_oe", 32'h0B, {24'h0, poe});
        chk("pin_o", 32'h01, {24'h0, po});
        chk("analog_sel", 32'h0, {24'h0, asel});
        rchk("input level", cgs_pkg::IDX_ILEVEL, 8'hA5);
        wreg(cgs_pkg::IDX_GENCTL, 8'h04);
        chk("analog_sel", 32'hFF, {24'h0, asel});
        repeat (2) @(posedge aclk);
        chk("pin_oe", 32'h0, {24'h0, poe});
        wreg(cgs_pkg::IDX_GENCTL, 8'h00);
        wreg(cgs_pkg::IDX_FUNC, 8'h0F);
        chk("analog_sel", 32'hF0, {24'h0, asel});
        $display("test pins done");
    endtask : t_pins
    task automatic t_manual;
        wreg(cgs_pkg::IDX_FUNC, 8'h00);
        wreg(cgs_pkg::IDX_SCAN, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wreg(cgs_pkg::IDX_MANUAL, 8'(c));
            chk("channel", 32'(c), {28'h0, cch});
            chk("valid", 32'h1, {31'h0, cv});
        end
        for (int m = 2; m < 4; m++) begin
            wreg(cgs_pkg::IDX_SCAN, 8'(m));
            chk("mode", 32'(m), {30'h0, mode});
            chk("valid", 32'h0, {31'h0, cv});
        end
        $display("test manual done");
    endtask : t_manual
    task automatic t_auto;
        logic [3:0] c;
        int n;
        wreg(cgs_pkg::IDX_MASK, 8'h25);
        wreg(cgs_pkg::IDX_SCAN, 8'h11);
        n = 0;
        while (act !== 1'h1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        chk("scan_active", 32'h1, {31'h0, act});
        c = cch;
        chk("mask hit", 32'h1, {31'h0, 1'(8'h25 >> c)});
        for (int s = 0; s < 4; s++) begin
            n = 0;
            do begin
                @(posedge aclk);
                n++;
            end while ((cch === c || cv !== 1'h1) && n < 100);
            chk("scan step", {28'h0, up(8'h25, c)}, {28'h0, cch});
            c = cch;
        end
        rchk("status", cgs_pkg::IDX_STATUS, 8'h40);
        wreg(cgs_pkg::IDX_SCAN, 8'h01);
        repeat (2) @(posedge aclk);
        chk("scan_active", 32'h0, {31'h0, act});
        rchk("status", cgs_pkg::IDX_STATUS, 8'h00);
        $display("test auto done");
    endtask : t_auto
    initial begin
        {aresetn, awv, wv, br, arv, rr, awa, ara, wd, ws} = '0;
        ext_en = 8'hFF;
        ext_val = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_fields;
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_pins;
        t_manual;
        t_auto;
        results;
    end
    initial begin
        #1000000;
        n_fail++;
        results;
    end
endmodule : tb_channel_gpio_sequencer_regs
`default_nettype wire
